// *** rcr_pkg.sv ***
// Package for the regulator control register bank: offsets, fields, resets, carrier types
// Summary of operation
// RULE1: Enable bit 0 turns regulator four on
// RULE2: Bit 1 forces PWM, else auto PFM/PWM
// RULE3: Bit 3 selects voltage register a or b
// RULE4: Bit 4 enables OV/UV/SC/ILIM comparators
// RULE5: Bit 5 connects pull-down while disabled
// RULE6: Bit 7 enables residual voltage check
// RULE7: Current-limit code in config bits 5:3
// RULE8: Current-limit change accepted any time
// RULE9: Slew code bits 2:0, both edges
// RULE10: Two full-byte voltage codes per regulator
// RULE11: Defaults loaded from non-volatile memory
// RULE12: Control and config reset to 0x22; code loads nvmCtrl4/nvmConf4 at reset instead
// RULE13: Reserved bits writable, reset to zero; code loads them from the NVM bytes at reset instead
// RULE14: Reserved bits hold value, no effect
package rcr_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL4 = 8'h0A;
	localparam logic [7:0] OFF_CONF4 = 8'h0B;
	localparam logic [7:0] OFF_V1A = 8'h0E;
	localparam logic [7:0] OFF_V1B = 8'h0F;
	localparam logic [7:0] OFF_V2A = 8'h10;
	localparam logic [7:0] OFF_V2B = 8'h11;
	localparam logic [7:0] OFF_V3A = 8'h12;
	localparam logic [7:0] OFF_V3B = 8'h13;
	localparam logic [7:0] RST_CTRL4 = 8'h22;
	localparam logic [7:0] RST_CONF4 = 8'h22;
	localparam logic [7:0] RST_VOLT = 8'h00;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	localparam logic [2:0] ILIM_MIN_CODE = 3'h2;
	localparam logic [2:0] ILIM_SAFE_CODE = 3'h2;
	localparam logic [2:0] ILIM_GAP_CODE = 3'h5;

	typedef struct packed {
		logic residualCheckEnable;
		logic reservedCtrl6;
		logic outputPulldownEnable;
		logic monitorComparatorEnable;
		logic voltageRegisterSelect;
		logic reservedCtrl2;
		logic forcedPwmSelect;
		logic regulatorEnable;
	} rcr_ctrl_t;

	typedef struct packed {
		logic [1:0] reservedConf;
		logic [2:0] peakCurrentLimitCode;
		logic [2:0] slewRateCode;
	} rcr_conf_t;

	// Host access strobe with address and data
	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [7:0] addr;
		logic [7:0] wrData;
	} rcr_bus_t;

	// Settings driven to the analog regulators
	typedef struct packed {
		logic regulatorEnable;
		logic forcedPwmSelect;
		logic monitorComparatorEnable;
		logic pulldownConnect;
		logic residualCheckEnable;
		logic [2:0] peakCurrentLimitCode;
		logic [2:0] slewRateCode;
		logic [7:0] reg4VoltageSelectIsB;
		logic [7:0] reg1VoltageCode;
		logic [7:0] reg2VoltageCode;
		logic [7:0] reg3VoltageCode;
	} rcr_out_t;

	typedef struct packed {
		rcr_ctrl_t ctrl4;
		rcr_conf_t conf4;
		logic [5:0][7:0] volt;
		logic [7:0] rdData;
		logic rdValid;
		rcr_out_t outs;
	} rcr_state_t;
endpackage : rcr_pkg

// *** rcr_regs.sv ***
// Register bank for regulator four control/config and regulator 1-3 voltage codes
`timescale 1ns/1ps
module rcr_regs #(
	parameter logic [2:0] ILIM_CAP = 3'h7
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Non-volatile defaults, sampled while reset is high
	input wire logic [7:0] nvmCtrl4,
	input wire logic [7:0] nvmConf4,
	input wire logic [5:0][7:0] nvmVolt,
	// Host register access
	input wire rcr_pkg::rcr_bus_t bus,
	output logic [7:0] rdData,
	output logic rdValid,
	// Settings to the regulators
	output rcr_pkg::rcr_out_t regOut
);
	import rcr_pkg::*;

	// Lanes of the voltage array, one pair per regulator
	localparam int V1A_IDX = 0;
	localparam int V1B_IDX = 1;
	localparam int V2A_IDX = 2;
	localparam int V2B_IDX = 3;
	localparam int V3A_IDX = 4;
	localparam int V3B_IDX = 5;

	// Zero bits above the select bit in its byte-wide output field
	localparam int SEL_PAD_W = 7;
	localparam logic [SEL_PAD_W-1:0] SEL_PAD = '0;

	// Select bits of regulators 1 to 3 live outside this bank, so register a is used
	localparam logic OTHER_SEL = 1'b0;

	rcr_state_t s_q, s_d;

	// Control register address
	function automatic logic isCtrl(input logic [7:0] a);
		isCtrl = (a == OFF_CTRL4);
	endfunction : isCtrl

	// Configuration register address
	function automatic logic isConf(input logic [7:0] a);
		isConf = (a == OFF_CONF4);
	endfunction : isConf

	// Any of the six voltage code registers
	function automatic logic isVolt(input logic [7:0] a);
		isVolt = (a >= OFF_V1A) && (a <= OFF_V3B);
	endfunction : isVolt

	// Lane of a voltage register; only meaningful while isVolt holds
	function automatic logic [2:0] voltIndex(input logic [7:0] a);
		voltIndex = 3'(a - OFF_V1A);
	endfunction : voltIndex

	function automatic logic [7:0] pickVolt(input logic sel, input logic [7:0] a, input logic [7:0] b);
		pickVolt = sel ? b : a; // RULE3 RULE10
	endfunction : pickVolt

	// Reserved and gap codes have no defined limit
	function automatic logic ilimLegal(input logic [2:0] code);
		case (code)
			ILIM_GAP_CODE: begin
				ilimLegal = 1'b0;
			end
			default: begin
				ilimLegal = (code >= ILIM_MIN_CODE);
			end
		endcase
	endfunction : ilimLegal

	// Undefined codes fall back to the lowest limit, so the switch is never left unprotected
	function automatic logic [2:0] ilimApply(input logic [2:0] code);
		if (!ilimLegal(code)) begin
			ilimApply = ILIM_SAFE_CODE; // RULE7
		end else if (code > ILIM_CAP) begin
			ilimApply = ILIM_CAP; // RULE8
		end else begin
			ilimApply = code; // RULE7
		end
	endfunction : ilimApply

	// Pull-down acts only on a disabled regulator
	function automatic logic pulldownOn(input rcr_ctrl_t c);
		pulldownOn = c.outputPulldownEnable && !c.regulatorEnable; // RULE5
	endfunction : pulldownOn

	// Regulator on or off
	function automatic logic enableOut(input rcr_ctrl_t c);
		enableOut = c.regulatorEnable; // RULE1
	endfunction : enableOut

	// Forced PWM or automatic PFM/PWM
	function automatic logic pwmOut(input rcr_ctrl_t c);
		pwmOut = c.forcedPwmSelect; // RULE2
	endfunction : pwmOut

	// Fault comparators on or off
	function automatic logic monitorOut(input rcr_ctrl_t c);
		monitorOut = c.monitorComparatorEnable; // RULE4
	endfunction : monitorOut

	// Residual voltage check on the feedback pin
	function automatic logic residualOut(input rcr_ctrl_t c);
		residualOut = c.residualCheckEnable; // RULE6
	endfunction : residualOut

	// Slew code used for rising and falling ramps alike
	function automatic logic [2:0] slewOut(input rcr_conf_t f);
		slewOut = f.slewRateCode; // RULE9
	endfunction : slewOut

	// Voltage register select widened to its output field
	function automatic logic [7:0] selOut(input rcr_ctrl_t c);
		selOut = {SEL_PAD, c.voltageRegisterSelect}; // RULE3
	endfunction : selOut

	// Read mux; the value returned is the one stored before any write of the same cycle
	function automatic logic [7:0] readMux(input rcr_state_t st, input logic [7:0] a);
		if (isCtrl(a)) begin
			readMux = st.ctrl4;
		end else if (isConf(a)) begin
			readMux = st.conf4;
		end else if (isVolt(a)) begin
			readMux = st.volt[voltIndex(a)];
		end else begin
			readMux = RD_UNMAPPED;
		end
	endfunction : readMux

	// Merges one host write; unmapped addresses leave everything as it was
	function automatic rcr_state_t writeBank(input rcr_state_t st, input rcr_bus_t b);
		writeBank = st;
		case (b.addr)
			OFF_CTRL4: begin
				// Reserved bits are stored like any other
				writeBank.ctrl4 = rcr_ctrl_t'(b.wrData); // RULE13 RULE14
			end
			OFF_CONF4: begin
				writeBank.conf4 = rcr_conf_t'(b.wrData); // RULE8 RULE13
			end
			OFF_V1A: begin
				writeBank.volt[V1A_IDX] = b.wrData; // RULE10
			end
			OFF_V1B: begin
				writeBank.volt[V1B_IDX] = b.wrData; // RULE10
			end
			OFF_V2A: begin
				writeBank.volt[V2A_IDX] = b.wrData; // RULE10
			end
			OFF_V2B: begin
				writeBank.volt[V2B_IDX] = b.wrData; // RULE10
			end
			OFF_V3A: begin
				writeBank.volt[V3A_IDX] = b.wrData; // RULE10
			end
			OFF_V3B: begin
				writeBank.volt[V3B_IDX] = b.wrData; // RULE10
			end
			default: begin
				writeBank = st;
			end
		endcase
	endfunction : writeBank

	// Defaults come from non-volatile memory, not from fixed reset values
	function automatic rcr_state_t loadDefaults(
		input rcr_state_t st,
		input logic [7:0] c,
		input logic [7:0] f,
		input logic [5:0][7:0] v
	);
		loadDefaults = st;
		loadDefaults.ctrl4 = rcr_ctrl_t'(c); // RULE11 RULE12
		loadDefaults.conf4 = rcr_conf_t'(f); // RULE11 RULE12
		loadDefaults.volt = v; // RULE11
		loadDefaults.rdData = RD_UNMAPPED;
		loadDefaults.rdValid = 1'b0;
	endfunction : loadDefaults

	// Settings handed to the regulators; reserved bits steer nothing
	function automatic rcr_out_t outsFrom(input rcr_ctrl_t c, input rcr_conf_t f, input logic [5:0][7:0] v);
		outsFrom.regulatorEnable = enableOut(c);
		outsFrom.forcedPwmSelect = pwmOut(c);
		outsFrom.monitorComparatorEnable = monitorOut(c);
		outsFrom.pulldownConnect = pulldownOn(c);
		outsFrom.residualCheckEnable = residualOut(c);
		outsFrom.peakCurrentLimitCode = ilimApply(f.peakCurrentLimitCode);
		outsFrom.slewRateCode = slewOut(f);
		outsFrom.reg4VoltageSelectIsB = selOut(c);
		outsFrom.reg1VoltageCode = pickVolt(OTHER_SEL, v[V1A_IDX], v[V1B_IDX]);
		outsFrom.reg2VoltageCode = pickVolt(OTHER_SEL, v[V2A_IDX], v[V2B_IDX]);
		outsFrom.reg3VoltageCode = pickVolt(OTHER_SEL, v[V3A_IDX], v[V3B_IDX]);
	endfunction : outsFrom

	always_comb begin
		s_d = s_q;
		s_d.rdValid = 1'b0;
		if (reset) begin
			s_d = loadDefaults(s_q, nvmCtrl4, nvmConf4, nvmVolt);
		end else begin
			if (bus.rdEn) begin
				s_d.rdValid = 1'b1;
				s_d.rdData = readMux(s_q, bus.addr);
			end
			if (bus.wrEn) begin
				s_d = writeBank(s_d, bus);
			end
		end
		// Outputs follow the fields as they will be stored
		s_d.outs = outsFrom(s_d.ctrl4, s_d.conf4, s_d.volt);
	end

	always_ff @(posedge clk) begin
		s_q <= s_d;
	end

	assign rdData = s_q.rdData;
	assign rdValid = s_q.rdValid;
	assign regOut = s_q.outs;
endmodule : rcr_regs

// *** rcr_regs_props.sv ***
// Checker for the regulator control register bank
`timescale 1ns/1ps
module rcr_regs_props import rcr_pkg::*; #(
	parameter logic [2:0] ILIM_CAP = 3'h7
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] nvmCtrl4,
	input wire logic [7:0] nvmConf4,
	input wire logic [5:0][7:0] nvmVolt,
	input wire rcr_bus_t bus,
	input wire logic [7:0] rdData,
	input wire logic rdValid,
	input wire rcr_out_t regOut
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire wc = bus.wrEn && bus.addr == OFF_CTRL4;
	wire wf = bus.wrEn && bus.addr == OFF_CONF4;
	wire [7:0] d = bus.wrData;
	rd_answer_a: assert property (bus.rdEn |=> rdValid) else $error("read lost");
	rd_quiet_a: assert property (!bus.rdEn |=> !rdValid) else $error("stray read");
	enable_bit_a: assert property (wc |=> regOut.regulatorEnable == $past(d[0])) else $error("en");
	pwm_bit_a: assert property (wc |=> regOut.forcedPwmSelect == $past(d[1])) else $error("pwm");
	vsel_bit_a: assert property (wc |=> regOut.reg4VoltageSelectIsB[0] == $past(d[3])) else $error("vsel");
	mon_bit_a: assert property (wc |=> regOut.monitorComparatorEnable == $past(d[4])) else $error("mon");
	pull_down_a: assert property (wc |=> regOut.pulldownConnect == ($past(d[5]) && !$past(d[0])))
		else $error("pulldown");
	resid_bit_a: assert property (wc |=> regOut.residualCheckEnable == $past(d[7])) else $error("rv");
	slew_code_a: assert property (wf |=> regOut.slewRateCode == $past(d[2:0])) else $error("slew");
	ilim_code_a: assert property (wf && d[5:3] inside {3'h2, 3'h3, 3'h4, 3'h6, 3'h7} && d[5:3] <= ILIM_CAP
		|=> regOut.peakCurrentLimitCode == $past(d[5:3])) else $error("ilim");
	volt_code_a: assert property (bus.wrEn && bus.addr == OFF_V1A |=> regOut.reg1VoltageCode == $past(d))
		else $error("volt");
	cover property (wc ##1 regOut.pulldownConnect);
	cover property (wf && d[5:3] == 3'h0);
	cover property (bus.rdEn && bus.wrEn);
endmodule : rcr_regs_props
bind rcr_regs rcr_regs_props #(.ILIM_CAP(ILIM_CAP)) rcr_regs_props_i (.clk(clk), .reset(reset),
	.nvmCtrl4(nvmCtrl4), .nvmConf4(nvmConf4), .nvmVolt(nvmVolt), .bus(bus), .rdData(rdData),
	.rdValid(rdValid), .regOut(regOut));

// *** rcr_regs_test.sv ***
// Self-checking bench for the regulator control register bank
`timescale 1ns/1ps
module rcr_regs_test;
	import rcr_pkg::*;
	logic clk = 0, reset = 1, rdValid;
	logic [7:0] nvmCtrl4 = RST_CTRL4, nvmConf4 = RST_CONF4, rdData;
	logic [5:0][7:0] nvmVolt = '0;
	rcr_bus_t bus = '0;
	rcr_out_t regOut;
	logic [7:0] m [8];
	logic [7:0] q [$];
	logic [31:0] lf = 32'h35EB998B;
	int errCount = 0, nTests = 0, cyc = 0;
	rcr_regs rcr_regs_i (.clk(clk), .reset(reset), .nvmCtrl4(nvmCtrl4), .nvmConf4(nvmConf4),
		.nvmVolt(nvmVolt), .bus(bus), .rdData(rdData), .rdValid(rdValid), .regOut(regOut));
	always #5 clk = ~clk;
	// Index 8 lands on an address outside the bank
	function logic [7:0] oa(int i);
		return 8'(i < 2 ? 10 + i : 12 + i);
	endfunction : oa
	function logic [7:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf[7:0];
	endfunction : rnd
	// Read sees the old value when it shares a cycle with a write
	task automatic acc(logic w, logic r, int i, logic [7:0] dt);
		@(negedge clk);
		bus <= '{w, r, oa(i), dt};
		if (r) q.push_back(i < 8 ? m[i] : RD_UNMAPPED);
		if (w && i < 8) m[i] = dt;
	endtask : acc
	task automatic rdall();
		for (int i = 0; i < 9; i++) acc(0, 1, i, 8'h00);
	endtask : rdall
	task automatic idle();
		@(negedge clk);
		bus <= '0;
	endtask : idle
	task automatic chk(logic [7:0] got);
		logic [7:0] e;
		nTests++;
		if (q.size() == 0) begin
			errCount++;
			$display("BAD %0t read with nothing expected", $time);
		end else begin
			e = q.pop_front();
			if (got !== e) begin
				errCount++;
				$display("BAD %0t read %h want %h", $time, got, e);
			end
		end
	endtask : chk
	// Settings expected from the modelled registers; undefined limit codes apply the lowest limit
	task automatic chkOut();
		rcr_out_t e;
		logic [2:0] lim;
		lim = m[1][5:3];
		if (!(lim inside {3'h2, 3'h3, 3'h4, 3'h6, 3'h7})) lim = 3'h2;
		e = '{m[0][0], m[0][1], m[0][4], m[0][5] && !m[0][0], m[0][7], lim, m[1][2:0], {7'h00, m[0][3]}, m[2], m[4], m[6]};
		nTests++;
		if (regOut !== e) begin
			errCount++;
			$display("BAD %0t settings %h want %h", $time, regOut, e);
		end
	endtask : chkOut
	task automatic summarize();
		$display("errors %0d checks %0d", errCount, nTests);
		if (errCount == 0 && nTests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : summarize
	always @(negedge clk) if (rdValid === 1'b1) chk(rdData);
	always @(posedge clk) if (++cyc > 3000) begin
		errCount++;
		summarize();
	end
	initial begin
		foreach (m[i]) m[i] = i == 0 ? RST_CTRL4 : i == 1 ? RST_CONF4 : RST_VOLT;
		repeat (6) @(negedge clk);
		reset <= 0;
		rdall();
		idle();
		chkOut();
		for (int k = 0; k < 60; k++) begin
			acc(1, k[0], k % 9, rnd());
			idle();
			chkOut();
		end
		for (int c = 0; c < 8; c++) begin
			acc(1, 1, 1, {2'h3, 3'(c), 3'(c)});
			idle();
			chkOut();
		end
		rdall();
		idle();
		nvmCtrl4 <= rnd();
		nvmConf4 <= rnd();
		nvmVolt <= {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
		reset <= 1;
		repeat (2) @(negedge clk);
		reset <= 0;
		m[0] = nvmCtrl4;
		m[1] = nvmConf4;
		for (int i = 0; i < 6; i++) m[i + 2] = nvmVolt[i];
		rdall();
		idle();
		chkOut();
		repeat (3) @(negedge clk);
		summarize();
	end
endmodule : rcr_regs_test
